// ===== tcu_pkg.sv
// constants and register layout of the 8-bit timer counter with two compare units
package tcu_pkg;
   localparam int          ADDR_W          = 5;
   localparam int          DATA_W          = 32;
   localparam int          CNT_W           = 8;

   localparam logic [4:0]  OFF_CONTROL_A   = 5'h00;
   localparam logic [4:0]  OFF_CONTROL_B   = 5'h04;
   localparam logic [4:0]  OFF_COUNT       = 5'h08;
   localparam logic [4:0]  OFF_COMPARE_A   = 5'h0c;
   localparam logic [4:0]  OFF_COMPARE_B   = 5'h10;
   localparam logic [4:0]  OFF_FLAGS       = 5'h14;
   localparam logic [4:0]  OFF_INT_ENABLE  = 5'h18;
   localparam logic [4:0]  OFF_STATUS      = 5'h1c;

   // control a: action a [7:6], action b [5:4], mode bits 1..0 [1:0]
   localparam int          CTLA_ACT_A_LSB  = 6;
   localparam int          CTLA_ACT_B_LSB  = 4;
   localparam int          CTLA_WGM_LSB    = 0;
   // control b: force a [7], force b [6], mode bit 2 [3], clock source [2:0]
   localparam int          CTLB_FORCE_A    = 7;
   localparam int          CTLB_FORCE_B    = 6;
   localparam int          CTLB_WGM2       = 3;
   localparam int          CTLB_CSS_LSB    = 0;
   // flags, interrupt enables and acknowledges share this order
   localparam int          FLAG_OVF        = 0;
   localparam int          FLAG_CMA        = 1;
   localparam int          FLAG_CMB        = 2;
   // status: output state a [0], output state b [1], counting down [2]
   localparam int          STAT_DOWN       = 2;

   localparam logic [7:0]  COUNT_BOTTOM    = 8'h00;
   localparam logic [7:0]  COUNT_MAX       = 8'hff;
   localparam logic [2:0]  CSS_STOPPED     = 3'h0;

   localparam logic [2:0]  MODE_NORMAL     = 3'h0;
   localparam logic [2:0]  MODE_PC_MAX     = 3'h1;
   localparam logic [2:0]  MODE_CTC        = 3'h2;
   localparam logic [2:0]  MODE_FAST_MAX   = 3'h3;
   localparam logic [2:0]  MODE_PC_CMPA    = 3'h5;
   localparam logic [2:0]  MODE_FAST_CMPA  = 3'h7;
   localparam logic [1:0]  WGM_LO_PC       = 2'h1;
   localparam logic [1:0]  WGM_LO_FAST     = 2'h3;

   localparam logic [1:0]  ACT_NONE        = 2'h0;
   localparam logic [1:0]  ACT_TOGGLE      = 2'h1;
   localparam logic [1:0]  ACT_CLEAR       = 2'h2;
   localparam logic [1:0]  ACT_SET         = 2'h3;

   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage

// ===== tcu_timer.sv
// timer counter unit with two compare channels behind an axi4-lite register slave
//
// Added by the designer: the AXI4-Lite register port and the address map.
module tcu_timer (
   input  wire logic                          aclk,            // system clock
   input  wire logic                          aresetn,         // synchronous reset, active low
   input  wire logic [tcu_pkg::ADDR_W-1:0]    s_axi_awaddr,    // write address
   input  wire logic                          s_axi_awvalid,   // write address valid
   output logic                               s_axi_awready,   // write address ready
   input  wire logic [tcu_pkg::DATA_W-1:0]    s_axi_wdata,     // write data
   input  wire logic [3:0]                    s_axi_wstrb,     // write byte enables
   input  wire logic                          s_axi_wvalid,    // write data valid
   output logic                               s_axi_wready,    // write data ready
   output logic [1:0]                         s_axi_bresp,     // write response
   output logic                               s_axi_bvalid,    // write response valid
   input  wire logic                          s_axi_bready,    // write response ready
   input  wire logic [tcu_pkg::ADDR_W-1:0]    s_axi_araddr,    // read address
   input  wire logic                          s_axi_arvalid,   // read address valid
   output logic                               s_axi_arready,   // read address ready
   output logic [tcu_pkg::DATA_W-1:0]         s_axi_rdata,     // read data
   output logic [1:0]                         s_axi_rresp,     // read response
   output logic                               s_axi_rvalid,    // read data valid
   input  wire logic                          s_axi_rready,    // read data ready
   input  wire logic                          timer_tick,      // one-cycle tick from clock selector
   input  wire logic [2:0]                    service_ack,     // interrupt serviced, per flag
   output logic [2:0]                         clock_source_select, // to clock selector
   output logic                               compare_output_a, // output state a
   output logic                               compare_output_b, // output state b
   output logic                               irq_overflow,    // overflow request
   output logic                               irq_compare_a,   // compare a request
   output logic                               irq_compare_b    // compare b request
);
   localparam int NCH = 2;

   // bus side state
   logic                        aw_held;
   logic                        w_held;
   logic [tcu_pkg::ADDR_W-1:0]  aw_addr_q;
   logic [7:0]                  w_byte_q;
   logic                        w_strb0_q;
   logic                        wr_do;
   logic                        wr_ok;
   logic [tcu_pkg::DATA_W-1:0]  rd_word;
   logic                        rd_ok;

   // register contents
   logic [7:0]                  control_a;
   logic [1:0]                  wgm_lo;
   logic                        waveform_mode_bit2;
   logic [2:0]                  flags;
   logic [2:0]                  int_enable;
   logic [7:0]                  timer_count;
   logic                        count_down;
   logic                        block_match;

   // datapath
   logic [2:0]                  waveform_mode_select;
   logic                        tick;
   logic                        cnt_wr;
   logic                        mode_pc;
   logic                        mode_fast;
   logic                        mode_pwm;
   logic                        top_is_cmpa;
   logic [7:0]                  top_value;
   logic                        at_top;
   logic                        at_bottom;
   logic                        at_max;
   logic [7:0]                  next_count;
   logic                        next_down;
   logic                        ovf_event;
   logic                        flag_w1c;
   logic [NCH-1:0]              cm_event;
   logic [NCH-1:0]              oc;
   logic [7:0]                  compare_value [NCH];
   logic [7:0]                  compare_buf [NCH];

   assign waveform_mode_select = {waveform_mode_bit2, wgm_lo};
   assign tick        = timer_tick && (clock_source_select != tcu_pkg::CSS_STOPPED);
   assign cnt_wr      = wr_do && w_strb0_q && (aw_addr_q == tcu_pkg::OFF_COUNT);
   assign mode_pc     = (wgm_lo == tcu_pkg::WGM_LO_PC);
   assign mode_fast   = (wgm_lo == tcu_pkg::WGM_LO_FAST);
   assign mode_pwm    = mode_pc || mode_fast;
   assign top_is_cmpa = (waveform_mode_select == tcu_pkg::MODE_CTC)
                        || (waveform_mode_select == tcu_pkg::MODE_PC_CMPA)
                        || (waveform_mode_select == tcu_pkg::MODE_FAST_CMPA);
   assign top_value   = top_is_cmpa ? compare_value[0] : tcu_pkg::COUNT_MAX;
   assign at_top      = (timer_count == top_value);
   assign at_bottom   = (timer_count == tcu_pkg::COUNT_BOTTOM);
   assign at_max      = (timer_count == tcu_pkg::COUNT_MAX);
   assign flag_w1c    = wr_do && w_strb0_q && (aw_addr_q == tcu_pkg::OFF_FLAGS);

   // ---------------- axi4-lite write channel ----------------
   // both halves are parked until the pair is complete, so arrival order is free
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign wr_do         = aw_held && w_held;

   always_comb begin
      unique case (aw_addr_q)
         tcu_pkg::OFF_CONTROL_A, tcu_pkg::OFF_CONTROL_B, tcu_pkg::OFF_COUNT,
         tcu_pkg::OFF_COMPARE_A, tcu_pkg::OFF_COMPARE_B, tcu_pkg::OFF_FLAGS,
         tcu_pkg::OFF_INT_ENABLE, tcu_pkg::OFF_STATUS: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held   <= 1'b0;
         aw_addr_q <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held   <= 1'b1;
         aw_addr_q <= s_axi_awaddr;
      end else if (wr_do) begin
         aw_held   <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held    <= 1'b0;
         w_byte_q  <= 8'h00;
         w_strb0_q <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held    <= 1'b1;
         w_byte_q  <= s_axi_wdata[7:0];
         w_strb0_q <= s_axi_wstrb[0];
      end else if (wr_do) begin
         w_held    <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= tcu_pkg::RESP_OKAY;
      end else if (wr_do) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_ok ? tcu_pkg::RESP_OKAY : tcu_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ---------------- axi4-lite read channel ----------------
   assign s_axi_arready = !s_axi_rvalid;

   always_comb begin
      rd_word = '0;
      rd_ok   = 1'b1;
      unique case (s_axi_araddr)
         tcu_pkg::OFF_CONTROL_A:  rd_word[7:0] = control_a;
         tcu_pkg::OFF_CONTROL_B:  rd_word[7:0] = {4'h0, waveform_mode_bit2, clock_source_select};
         tcu_pkg::OFF_COUNT:      rd_word[7:0] = timer_count;
         tcu_pkg::OFF_COMPARE_A:  rd_word[7:0] = compare_buf[0];
         tcu_pkg::OFF_COMPARE_B:  rd_word[7:0] = compare_buf[1];
         tcu_pkg::OFF_FLAGS:      rd_word[2:0] = flags;
         tcu_pkg::OFF_INT_ENABLE: rd_word[2:0] = int_enable;
         tcu_pkg::OFF_STATUS:     rd_word[2:0] = {count_down, oc};
         default:                 rd_ok        = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= tcu_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= rd_ok ? tcu_pkg::RESP_OKAY : tcu_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ---------------- control registers ----------------
   // action bits drive the output logic straight from this register, never via a shadow
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         control_a <= 8'h00;
      end else if (wr_do && w_strb0_q && aw_addr_q == tcu_pkg::OFF_CONTROL_A) begin
         control_a <= w_byte_q;
      end
   end
   assign wgm_lo = control_a[tcu_pkg::CTLA_WGM_LSB +: 2];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         waveform_mode_bit2  <= 1'b0;
         clock_source_select <= tcu_pkg::CSS_STOPPED;
      end else if (wr_do && w_strb0_q && aw_addr_q == tcu_pkg::OFF_CONTROL_B) begin
         waveform_mode_bit2  <= w_byte_q[tcu_pkg::CTLB_WGM2];
         clock_source_select <= w_byte_q[tcu_pkg::CTLB_CSS_LSB +: 3];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         int_enable <= 3'h0;
      end else if (wr_do && w_strb0_q && aw_addr_q == tcu_pkg::OFF_INT_ENABLE) begin
         int_enable <= w_byte_q[2:0];
      end
   end

   // ---------------- counter unit ----------------
   always_comb begin
      next_count = timer_count;
      next_down  = 1'b0;
      if (mode_pc) begin
         // dual slope: turn round at top and at bottom
         if (!count_down) begin
            next_count = at_top ? timer_count - 8'h01 : timer_count + 8'h01;
            next_down  = at_top;
         end else begin
            next_count = at_bottom ? timer_count + 8'h01 : timer_count - 8'h01;
            next_down  = !at_bottom;
         end
      end else begin
         next_count = at_top ? tcu_pkg::COUNT_BOTTOM : timer_count + 8'h01;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer_count <= tcu_pkg::COUNT_BOTTOM;
         count_down  <= 1'b0;
      end else if (cnt_wr) begin
         timer_count <= w_byte_q;
      end else if (tick) begin
         timer_count <= next_count;
         count_down  <= next_down;
      end
   end

   // normal and ctc overflow at max, fast pwm at top, phase correct at bottom
   assign ovf_event = tick && !cnt_wr
                      && (mode_pc ? (count_down && at_bottom) : (mode_fast ? at_top : at_max));

   // a count write arms the block; the next tick consumes it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         block_match <= 1'b0;
      end else if (cnt_wr) begin
         block_match <= 1'b1;
      end else if (tick) begin
         block_match <= 1'b0;
      end
   end

   // ---------------- compare channels ----------------
   genvar ch;
   generate
      for (ch = 0; ch < NCH; ch++) begin : g_ch
         logic [1:0] action;
         logic       cmp_wr;
         logic       force_cmp;
         logic       next_oc;

         assign action    = control_a[tcu_pkg::CTLA_ACT_A_LSB - 2*ch +: 2];
         assign cmp_wr    = wr_do && w_strb0_q
                            && (aw_addr_q == (ch == 0 ? tcu_pkg::OFF_COMPARE_A : tcu_pkg::OFF_COMPARE_B));
         assign force_cmp = wr_do && w_strb0_q && (aw_addr_q == tcu_pkg::OFF_CONTROL_B) && !mode_pwm
                            && w_byte_q[ch == 0 ? tcu_pkg::CTLB_FORCE_A : tcu_pkg::CTLB_FORCE_B];
         assign cm_event[ch] = tick && !cnt_wr && !block_match
                               && (timer_count == compare_value[ch]);

         // the buffer always takes the write; outside pwm the active copy follows at once
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               compare_buf[ch] <= 8'h00;
            end else if (cmp_wr) begin
               compare_buf[ch] <= w_byte_q;
            end
         end

         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               compare_value[ch] <= 8'h00;
            end else if (!mode_pwm && cmp_wr) begin
               compare_value[ch] <= w_byte_q;
            end else if (mode_pwm && tick && at_top) begin
               compare_value[ch] <= compare_buf[ch];
            end
         end

         always_comb begin
            next_oc = oc[ch];
            if (!mode_pwm) begin
               if (cm_event[ch] || force_cmp) begin
                  unique case (action)
                     tcu_pkg::ACT_NONE:   next_oc = oc[ch];
                     tcu_pkg::ACT_TOGGLE: next_oc = !oc[ch];
                     tcu_pkg::ACT_CLEAR:  next_oc = 1'b0;
                     tcu_pkg::ACT_SET:    next_oc = 1'b1;
                  endcase
               end
            end else if (cm_event[ch]) begin
               // in phase correct the level flips with the slope direction
               unique case (action)
                  tcu_pkg::ACT_NONE:   next_oc = oc[ch];
                  tcu_pkg::ACT_TOGGLE: next_oc = (ch == 0 && waveform_mode_bit2) ? !oc[ch] : oc[ch];
                  tcu_pkg::ACT_CLEAR:  next_oc = mode_pc && count_down;
                  tcu_pkg::ACT_SET:    next_oc = !(mode_pc && count_down);
               endcase
            end else if (mode_fast && tick && !cnt_wr && at_top) begin
               // wrap to bottom restores the idle level of the fast pwm output
               if (action == tcu_pkg::ACT_CLEAR) begin
                  next_oc = 1'b1;
               end else if (action == tcu_pkg::ACT_SET) begin
                  next_oc = 1'b0;
               end
            end
         end

         // no mode term in the reset or hold path, so a mode change keeps the level
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               oc[ch] <= 1'b0;
            end else begin
               oc[ch] <= next_oc;
            end
         end
      end
   endgenerate

   // ---------------- flags and requests ----------------
   // a set in the clearing cycle wins, so no event is lost
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags <= 3'h0;
      end else begin
         flags <= (flags & ~(service_ack | (flag_w1c ? w_byte_q[2:0] : 3'h0)))
                  | {cm_event[1], cm_event[0], ovf_event};
      end
   end

   assign irq_overflow     = flags[tcu_pkg::FLAG_OVF] && int_enable[tcu_pkg::FLAG_OVF];
   assign irq_compare_a    = flags[tcu_pkg::FLAG_CMA] && int_enable[tcu_pkg::FLAG_CMA];
   assign irq_compare_b    = flags[tcu_pkg::FLAG_CMB] && int_enable[tcu_pkg::FLAG_CMB];
   assign compare_output_a = oc[0];
   assign compare_output_b = oc[1];

   // ---------------- assertions ----------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   count_write_wins_a: assert property (cnt_wr |=> timer_count == $past(w_byte_q))
      else $error("count write did not override counting");
   stopped_holds_a: assert property ((clock_source_select == tcu_pkg::CSS_STOPPED) && !cnt_wr
                                     |=> $stable(timer_count))
      else $error("counter moved while stopped");
   // the block spans any number of idle cycles, so it is judged at the tick that consumes it
   write_blocks_a: assert property (block_match && tick
                                    |=> (flags[tcu_pkg::FLAG_CMB:tcu_pkg::FLAG_CMA]
                                         & ~$past(flags[tcu_pkg::FLAG_CMB:tcu_pkg::FLAG_CMA])) == 2'b00)
      else $error("compare match not blocked after count write");
   match_sets_flag_a: assert property (tick && !cnt_wr && !block_match && timer_count == compare_value[0]
                                       |=> flags[tcu_pkg::FLAG_CMA])
      else $error("compare a match did not set its flag");
   irq_gated_a: assert property (!int_enable[tcu_pkg::FLAG_CMB] |-> !irq_compare_b)
      else $error("compare b request without enable");
   w1c_clears_a: assert property (flag_w1c && w_byte_q[tcu_pkg::FLAG_CMA] && !cm_event[0]
                                  |=> !flags[tcu_pkg::FLAG_CMA])
      else $error("write one did not clear compare a flag");
   // a tick in the strobe cycle still counts normally, so such cycles are left out
   force_no_flag_a: assert property (g_ch[0].force_cmp && !tick && !cm_event[0] && !flags[tcu_pkg::FLAG_CMA]
                                     |=> !flags[tcu_pkg::FLAG_CMA] && $stable(timer_count))
      else $error("forced compare touched flag or counter");
   buffer_holds_a: assert property (mode_pwm && !(tick && at_top) |=> $stable(compare_value[1]))
      else $error("active compare b changed away from top");
   ctc_clear_a: assert property ((waveform_mode_select == tcu_pkg::MODE_CTC) && tick && !cnt_wr && at_top
                                 |=> timer_count == tcu_pkg::COUNT_BOTTOM)
      else $error("ctc did not clear at compare a");
endmodule

// ===== tcu_timer_test.sv
// self-checking bench for the timer counter with two compare units
module tcu_timer_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, tick;
   logic [4:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, v;
   logic [2:0]  ack, css;
   logic [1:0]  bresp, rresp, resp;
   logic        awready, wready, bvalid, arready, rvalid, oa, ob, iov, ica, icb;
   int          errors, cmp_count;

   tcu_timer tcu_timer_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .timer_tick(tick),
      .service_ack(ack), .clock_source_select(css), .compare_output_a(oa), .compare_output_b(ob),
      .irq_overflow(iov), .irq_compare_a(ica), .irq_compare_b(icb));

   initial begin
      aclk = 0;
      forever #5 aclk = ~aclk;
   end

   task chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // both channels offered together, each released when its ready is seen
   task wr(input logic [4:0] a, input logic [7:0] d);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do begin
         @(posedge aclk);
         n++;
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
         resp = bresp;
      end while (!bvalid && n < 50);
      if (n >= 50) begin
         errors++;
         wrap_up;
      end
      bready <= 0;
      @(posedge aclk);
   endtask

   task rd(input logic [4:0] a);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do begin
         @(posedge aclk);
         n++;
         if (arready) arvalid <= 0;
         v = rdata;
         resp = rresp;
      end while (!rvalid && n < 50);
      if (n >= 50) begin
         errors++;
         wrap_up;
      end
      rready <= 0;
      @(posedge aclk);
   endtask

   task tk(input int k);
      repeat (k) begin
         tick <= 1;
         @(posedge aclk);
         tick <= 0;
         @(posedge aclk);
      end
   endtask

   task t_stop;
      wr(tcu_pkg::OFF_CONTROL_B, 8'h00);
      chk({29'h0, css}, 32'h0);
      wr(tcu_pkg::OFF_COUNT, 8'h10);
      tk(3);
      rd(tcu_pkg::OFF_COUNT);
      chk(v, 32'h10);
      chk({31'h0, oa}, 32'h0);
      $display("stop test done");
   endtask

   task t_wrap;
      wr(tcu_pkg::OFF_COMPARE_A, 8'h80);
      wr(tcu_pkg::OFF_CONTROL_B, 8'h01);
      chk({29'h0, css}, 32'h1);
      wr(tcu_pkg::OFF_COUNT, 8'hfe);
      tk(2);
      rd(tcu_pkg::OFF_COUNT);
      chk(v, 32'h0);
      wr(tcu_pkg::OFF_INT_ENABLE, 8'h01);
      rd(tcu_pkg::OFF_FLAGS);
      chk(v & 32'h1, 32'h1);
      chk({31'h0, iov}, 32'h1);
      wr(tcu_pkg::OFF_FLAGS, 8'h01);
      chk({31'h0, iov}, 32'h0);
      $display("wrap test done");
   endtask

   task t_cmp;
      wr(tcu_pkg::OFF_COMPARE_A, 8'h20);
      wr(tcu_pkg::OFF_COUNT, 8'h20);
      tk(1);
      rd(tcu_pkg::OFF_FLAGS);
      chk(v & 32'h2, 32'h0);
      wr(tcu_pkg::OFF_COUNT, 8'h1f);
      tk(2);
      rd(tcu_pkg::OFF_FLAGS);
      chk(v & 32'h2, 32'h2);
      wr(tcu_pkg::OFF_INT_ENABLE, 8'h02);
      chk({31'h0, ica}, 32'h1);
      ack <= 3'h2;
      @(posedge aclk);
      ack <= 3'h0;
      @(posedge aclk);
      chk({31'h0, ica}, 32'h0);
      chk({31'h0, oa}, 32'h0);
      $display("compare test done");
   endtask

   // stopped timer, so only the strobe can move the output state
   task t_force;
      wr(tcu_pkg::OFF_FLAGS, 8'h07);
      wr(tcu_pkg::OFF_CONTROL_A, 8'h40);
      wr(tcu_pkg::OFF_CONTROL_B, 8'h80);
      chk({31'h0, oa}, 32'h1);
      rd(tcu_pkg::OFF_FLAGS);
      chk(v & 32'h2, 32'h0);
      rd(tcu_pkg::OFF_COUNT);
      chk(v, 32'h21);
      wr(tcu_pkg::OFF_CONTROL_A, 8'h43);
      chk({31'h0, oa}, 32'h1);
      wr(5'h02, 8'h55);
      chk({30'h0, resp}, {30'h0, tcu_pkg::RESP_SLVERR});
      rd(5'h02);
      chk({30'h0, resp}, {30'h0, tcu_pkg::RESP_SLVERR});
      chk(v, 32'h0);
      $display("force test done");
   endtask

   // fast pwm on channel b with top at max, then ctc and phase correct turns
   task t_pwm;
      wr(tcu_pkg::OFF_CONTROL_A, 8'h23);
      wr(tcu_pkg::OFF_COMPARE_B, 8'hf4);
      wr(tcu_pkg::OFF_COUNT, 8'hf2);
      wr(tcu_pkg::OFF_CONTROL_B, 8'h01);
      tk(3);
      rd(tcu_pkg::OFF_FLAGS);
      chk(v & 32'h4, 32'h0);
      tk(11);
      chk({31'h0, ob}, 32'h1);
      tk(245);
      rd(tcu_pkg::OFF_FLAGS);
      chk(v & 32'h4, 32'h4);
      chk({31'h0, ob}, 32'h0);
      wr(tcu_pkg::OFF_INT_ENABLE, 8'h04);
      chk({31'h0, icb}, 32'h1);
      wr(tcu_pkg::OFF_FLAGS, 8'h04);
      chk({31'h0, icb}, 32'h0);
      wr(tcu_pkg::OFF_CONTROL_A, 8'h02);
      wr(tcu_pkg::OFF_COUNT, 8'h1e);
      tk(3);
      rd(tcu_pkg::OFF_COUNT);
      chk(v, 32'h0);
      wr(tcu_pkg::OFF_CONTROL_A, 8'h01);
      wr(tcu_pkg::OFF_COUNT, 8'hfe);
      tk(2);
      rd(tcu_pkg::OFF_COUNT);
      chk(v, 32'hfe);
      rd(tcu_pkg::OFF_STATUS);
      chk(v & 32'h4, 32'h4);
      $display("pwm test done");
   endtask

   task wrap_up;
      $display("compares=%0d mismatches=%0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, tick} = '0;
      {awaddr, araddr, wdata, ack} = '0;
      errors = 0;
      cmp_count = 0;
      repeat (5) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      t_stop;
      t_wrap;
      t_cmp;
      t_force;
      t_pwm;
      wrap_up;
   end

   // the whole sequence needs a few hundred cycles
   initial begin
      #100us;
      errors++;
      wrap_up;
   end
endmodule
